// ### core/tws_core.sv
// Two-wire slave and clocked synchronous serial engine.
`timescale 1ns/100ps
module tws_core (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  input wire tws_pkg::tws_ctrl_t ctrl,
  input wire tws_pkg::tws_irq_en_t irq_en,
  input wire logic tx_wr,
  input wire logic [7:0] tx_data,
  input wire logic rx_rd,
  input wire logic tsel_set,
  input wire logic tsel_clr,
  input wire tws_pkg::tws_flags_t flag_clr,
  output logic [7:0] rx_data,
  output tws_pkg::tws_flags_t flags,
  output logic transmit_select,
  output logic clock_line_monitor,
  output tws_pkg::tws_irq_t irq
);
  logic rst_m_r;
  logic rst_s_r;
  logic [1:0] pin_w;
  logic [1:0] f1_w;
  logic [1:0] f2_w;
  logic [1:0] filt_w;
  logic [1:0] filt_d_w;
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_w;
  logic stop_w;
  logic out_bit;
  logic [7:0] sh_shl;
  logic [7:0] sh_in_w;
  logic addr_hit_w;
  logic run_w;
  logic [5:0] mon_c;
  tws_pkg::tws_state_t st_r;
  tws_pkg::tws_flags_t fl_r;
  logic [7:0] sh_r;
  logic [7:0] txb_r;
  logic [7:0] rxb_r;
  logic [3:0] bcnt_r;
  logic sda_en_r;
  logic sda_lvl_r;
  logic hold_r;
  logic dir_r;
  logic ack_lat_r;
  logic acked_r;
  logic tsel_r;
  logic sbusy_r;
  logic rx_halt_r;
  logic stop_after_r;
  logic gen_low_r;
  logic gen_ok_r;
  logic [5:0] gen_cnt_r;

  // Reset is released through two flops; all logic uses the copy.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // Each line is synchronised, then passes two latches and a match check.
  assign pin_w = {scl_in, sda_in};
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic m1_r;
    logic m2_r;
    logic l1_r;
    logic l2_r;
    logic fo_r;
    logic fd_r;
    always_ff @(posedge clk_sys or negedge rst_s_r) begin
      if (!rst_s_r) begin
        m1_r <= 1'b1;
        m2_r <= 1'b1;
        l1_r <= 1'b1;
        l2_r <= 1'b1;
        fo_r <= 1'b1;
        fd_r <= 1'b1;
      end else begin
        m1_r <= pin_w[i];
        m2_r <= m1_r;
        l1_r <= m2_r;
        l2_r <= l1_r;
        if (l1_r == l2_r) begin
          fo_r <= l2_r;
        end
        fd_r <= fo_r;
      end
    end
    assign f1_w[i] = l1_r;
    assign f2_w[i] = l2_r;
    assign filt_w[i] = fo_r;
    assign filt_d_w[i] = fd_r;
  end

  // Edges and bus conditions come from the filtered lines only.
  assign scl_f = filt_w[1];
  assign sda_f = filt_w[0];
  assign scl_rise = scl_f & ~filt_d_w[1];
  assign scl_fall = ~scl_f & filt_d_w[1];
  assign start_w = scl_f & filt_d_w[1] & filt_d_w[0] & ~sda_f;
  assign stop_w = scl_f & filt_d_w[1] & ~filt_d_w[0] & sda_f;

  // Shift helpers follow the bit order control.
  assign out_bit = ctrl.bit_order_select ? sh_r[0] : sh_r[7];
  assign sh_shl = ctrl.bit_order_select ? {1'b0, sh_r[7:1]} :
    {sh_r[6:0], 1'b0};
  assign sh_in_w = ctrl.bit_order_select ? {sda_f, sh_r[7:1]} :
    {sh_r[6:0], sda_f};
  assign addr_hit_w = (sh_r[7:1] == ctrl.own_address);

  // The generated clock runs while a synchronous byte has work to do.
  assign run_w = ctrl.interface_enable & ctrl.format_select &
    ctrl.master_select & (tsel_r ? sbusy_r : ~rx_halt_r);

  // Monitor time chosen by the upper clock rate bits.
  always_comb begin
    case (ctrl.clock_rate_select[tws_pkg::CKS_HI:tws_pkg::CKS_LO])
      2'h0: mon_c = tws_pkg::MON_C0;
      2'h1: mon_c = tws_pkg::MON_C1;
      2'h2: mon_c = tws_pkg::MON_C2;
      default: mon_c = tws_pkg::MON_C3;
    endcase
  end

  // Clock generator: low phase, release, then watch the line go high.
  always_ff @(posedge clk_sys or negedge rst_s_r) begin
    if (!rst_s_r) begin
      gen_low_r <= 1'b0;
      gen_ok_r <= 1'b1;
      gen_cnt_r <= 6'h00;
    end else if (gen_low_r) begin
      if (gen_cnt_r <= 6'h01) begin
        gen_low_r <= 1'b0;
        gen_ok_r <= 1'b0;
        gen_cnt_r <= mon_c;
      end else begin
        gen_cnt_r <= gen_cnt_r - 6'h01;
      end
    end else if (!gen_ok_r) begin
      if (gen_cnt_r > 6'h01) begin
        gen_cnt_r <= gen_cnt_r - 6'h01;
      end else if (scl_f) begin
        gen_ok_r <= 1'b1;
      end
    end else if (run_w) begin
      gen_low_r <= 1'b1;
      gen_cnt_r <= tws_pkg::LOW_C;
    end
  end

  // Transmit buffer holds what the host writes.
  always_ff @(posedge clk_sys or negedge rst_s_r) begin
    if (!rst_s_r) begin
      txb_r <= tws_pkg::BUF_RST;
    end else if (tx_wr) begin
      txb_r <= tx_data;
    end
  end

  // Serial engine with flags; host clears come first so that sets win.
  always_ff @(posedge clk_sys or negedge rst_s_r) begin
    if (!rst_s_r) begin
      st_r <= tws_pkg::ST_IDLE;
      fl_r <= '0;
      sh_r <= tws_pkg::BUF_RST;
      rxb_r <= tws_pkg::BUF_RST;
      bcnt_r <= 4'h0;
      sda_en_r <= 1'b0;
      sda_lvl_r <= 1'b1;
      hold_r <= 1'b0;
      dir_r <= 1'b0;
      ack_lat_r <= 1'b0;
      acked_r <= 1'b0;
      tsel_r <= 1'b0;
      sbusy_r <= 1'b0;
      rx_halt_r <= 1'b0;
      stop_after_r <= 1'b0;
    end else begin
      fl_r <= fl_r & ~flag_clr;
      if (tx_wr) begin
        fl_r.tx_buffer_empty <= 1'b0;
        fl_r.tx_end_flag <= 1'b0;
      end
      if (rx_rd) begin
        fl_r.rx_buffer_full <= 1'b0;
        ack_lat_r <= ctrl.ack_to_send;
      end
      if (tsel_clr) begin
        tsel_r <= 1'b0;
      end
      if (tsel_set) begin
        tsel_r <= 1'b1;
        if (ctrl.format_select) begin
          fl_r.tx_buffer_empty <= 1'b1;
        end
      end
      if (!ctrl.interface_enable) begin
        st_r <= tws_pkg::ST_IDLE;
        sda_en_r <= 1'b0;
        hold_r <= 1'b0;
        sbusy_r <= 1'b0;
      end else if (ctrl.format_select) begin
        // Clocked synchronous format.
        st_r <= tws_pkg::ST_IDLE;
        hold_r <= 1'b0;
        // A direction change starts a fresh byte, except when a clock rise in the same cycle counts on from the old count.
        if (tsel_set || tsel_clr) begin
          bcnt_r <= 4'h0;
        end
        if (tsel_r) begin
          sda_en_r <= 1'b1;
          if (!sbusy_r && !fl_r.tx_buffer_empty) begin
            sh_r <= txb_r;
            fl_r.tx_buffer_empty <= 1'b1;
            sbusy_r <= 1'b1;
            bcnt_r <= 4'h0;
          end
          if (scl_fall) begin
            sda_lvl_r <= sbusy_r ? out_bit : ctrl.data_line_out_level;
            if (!sbusy_r) begin
              bcnt_r <= 4'h0;
            end
          end else if (!sbusy_r && bcnt_r != tws_pkg::BIT_LAST) begin
            sda_lvl_r <= ctrl.data_line_out_level;
          end
          if (scl_rise && sbusy_r) begin
            sh_r <= sh_shl;
            bcnt_r <= bcnt_r + 4'h1;
            if (bcnt_r == tws_pkg::BIT_SEVENTH) begin
              sbusy_r <= 1'b0;
              if (fl_r.tx_buffer_empty) begin
                fl_r.tx_end_flag <= 1'b1;
              end
            end
          end
        end else begin
          sda_en_r <= 1'b0;
          sbusy_r <= 1'b0;
          if (!ctrl.receive_disable) begin
            rx_halt_r <= 1'b0;
          end
          if (rx_rd && ctrl.receive_disable && ctrl.master_select) begin
            stop_after_r <= 1'b1;
          end
          if (scl_rise && !rx_halt_r) begin
            sh_r <= sh_in_w;
            bcnt_r <= bcnt_r + 4'h1;
            if (bcnt_r >= tws_pkg::BIT_SEVENTH) begin
              bcnt_r <= 4'h0;
              if (fl_r.rx_buffer_full) begin
                fl_r.arb_lost_or_overrun <= 1'b1;
              end else begin
                rxb_r <= sh_in_w;
                fl_r.rx_buffer_full <= 1'b1;
              end
              if (stop_after_r) begin
                rx_halt_r <= 1'b1;
                stop_after_r <= 1'b0;
              end
            end
          end
        end
      end else if (stop_w) begin
        st_r <= tws_pkg::ST_IDLE;
        sda_en_r <= 1'b0;
        hold_r <= 1'b0;
        fl_r.stop_seen <= 1'b1;
      end else if (start_w) begin
        st_r <= tws_pkg::ST_ADDR;
        bcnt_r <= 4'h0;
        sda_en_r <= 1'b0;
        sda_lvl_r <= 1'b0;
        hold_r <= 1'b0;
      end else begin
        // Two-wire bus format; the line is pulled low while enabled.
        case (st_r)
          tws_pkg::ST_ADDR, tws_pkg::ST_RXD: begin
            if (scl_rise) begin
              sh_r <= sh_in_w;
              bcnt_r <= bcnt_r + 4'h1;
            end else if (scl_fall && bcnt_r == tws_pkg::BIT_LAST) begin
              if (st_r == tws_pkg::ST_ADDR) begin
                if (addr_hit_w) begin
                  sda_en_r <= ~ack_lat_r;
                  dir_r <= sh_r[0];
                  st_r <= tws_pkg::ST_AACK;
                end else begin
                  st_r <= tws_pkg::ST_SKIP;
                end
              end else if (fl_r.rx_buffer_full) begin
                hold_r <= 1'b1;
                st_r <= tws_pkg::ST_RHOLD;
              end else begin
                sda_en_r <= ~ack_lat_r;
                st_r <= tws_pkg::ST_RACK;
              end
            end
          end
          tws_pkg::ST_AACK: begin
            if (scl_rise) begin
              if (dir_r) begin
                tsel_r <= 1'b1;
              end else begin
                rxb_r <= sh_r;
                fl_r.rx_buffer_full <= 1'b1;
              end
            end else if (scl_fall) begin
              sda_en_r <= 1'b0;
              bcnt_r <= 4'h0;
              st_r <= dir_r ? tws_pkg::ST_TLOAD : tws_pkg::ST_RXD;
            end
          end
          tws_pkg::ST_RHOLD: begin
            if (rx_rd) begin
              hold_r <= 1'b0;
              sda_en_r <= ~ctrl.ack_to_send;
              st_r <= tws_pkg::ST_RACK;
            end
          end
          tws_pkg::ST_RACK: begin
            if (scl_rise) begin
              rxb_r <= sh_r;
              fl_r.rx_buffer_full <= 1'b1;
            end else if (scl_fall) begin
              sda_en_r <= 1'b0;
              bcnt_r <= 4'h0;
              st_r <= tws_pkg::ST_RXD;
            end
          end
          tws_pkg::ST_TLOAD: begin
            if (!fl_r.tx_buffer_empty) begin
              sh_r <= txb_r;
              fl_r.tx_buffer_empty <= 1'b1;
              sda_en_r <= ctrl.bit_order_select ? ~txb_r[0] : ~txb_r[7];
              hold_r <= 1'b0;
              bcnt_r <= 4'h0;
              st_r <= tws_pkg::ST_TXD;
            end else if (!tsel_r && rx_rd) begin
              hold_r <= 1'b0;
              st_r <= tws_pkg::ST_SKIP;
            end else begin
              hold_r <= 1'b1;
            end
          end
          tws_pkg::ST_TXD: begin
            if (scl_rise) begin
              sh_r <= sh_shl;
              bcnt_r <= bcnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bcnt_r == tws_pkg::BIT_LAST) begin
                sda_en_r <= 1'b0;
                st_r <= tws_pkg::ST_TACK;
              end else begin
                sda_en_r <= ~out_bit;
              end
            end
          end
          tws_pkg::ST_TACK: begin
            if (scl_rise) begin
              acked_r <= ~sda_f;
              if (sda_f) begin
                fl_r.nack_seen_flag <= 1'b1;
              end
              if (fl_r.tx_buffer_empty) begin
                fl_r.tx_end_flag <= 1'b1;
              end
            end else if (scl_fall) begin
              st_r <= acked_r ? tws_pkg::ST_TLOAD : tws_pkg::ST_SKIP;
            end
          end
          default: begin
            sda_en_r <= 1'b0;
            hold_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Registered outputs, requests and pin drive.
  always_ff @(posedge clk_sys or negedge rst_s_r) begin
    if (!rst_s_r) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      rx_data <= tws_pkg::BUF_RST;
      flags <= '0;
      transmit_select <= 1'b0;
      clock_line_monitor <= 1'b1;
      irq <= '0;
    end else begin
      scl_out <= 1'b0;
      scl_oe <= ctrl.format_select ? (ctrl.master_select & gen_low_r) :
        hold_r;
      sda_out <= sda_lvl_r;
      sda_oe <= sda_en_r;
      rx_data <= rxb_r;
      flags <= fl_r;
      transmit_select <= tsel_r;
      clock_line_monitor <= scl_f;
      irq.tx_empty_irq <= fl_r.tx_buffer_empty &
        irq_en.tx_empty_irq_enable;
      irq.tx_end_irq <= fl_r.tx_end_flag & irq_en.tx_end_irq_enable;
      irq.rx_full_irq <= fl_r.rx_buffer_full & irq_en.rx_full_irq_enable;
      irq.stop_seen_irq <= fl_r.stop_seen & ~ctrl.format_select &
        irq_en.stop_seen_irq_enable;
      irq.nack_error_irq <= ((fl_r.nack_seen_flag & ~ctrl.format_select) |
        fl_r.arb_lost_or_overrun) & irq_en.nack_error_irq_enable;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_s_r);

  a_addr_ack:
    assert property (st_r == tws_pkg::ST_ADDR && !start_w && !stop_w &&
      ctrl.interface_enable && !ctrl.format_select && scl_fall &&
      bcnt_r == 4'h8 && addr_hit_w |=> sda_en_r == !$past(ack_lat_r))
    else $error("ack level not driven after address match");
  a_dir_tsel:
    assert property (st_r == tws_pkg::ST_AACK && scl_rise && dir_r &&
      !start_w && !stop_w && ctrl.interface_enable &&
      !ctrl.format_select |=> tsel_r)
    else $error("transmit select not set on read address");
  a_load_empty:
    assert property (st_r == tws_pkg::ST_TLOAD && !fl_r.tx_buffer_empty &&
      !start_w && !stop_w && ctrl.interface_enable &&
      !ctrl.format_select |=> fl_r.tx_buffer_empty && sh_r == $past(txb_r))
    else $error("buffer move did not set empty flag");
  a_addr_full:
    assert property (st_r == tws_pkg::ST_AACK && scl_rise && !dir_r &&
      !start_w && !stop_w && ctrl.interface_enable &&
      !ctrl.format_select |=> fl_r.rx_buffer_full && rxb_r == $past(sh_r))
    else $error("address byte not placed in receive buffer");
  a_rx_stretch:
    assert property ((st_r == tws_pkg::ST_RHOLD) [*2] |-> scl_oe)
    else $error("clock not stretched while buffer full");
  a_tsel_empty:
    assert property (tsel_set && ctrl.format_select |=> fl_r.tx_buffer_empty)
    else $error("sync transmit select did not set empty flag");
  a_sync_recv:
    assert property (ctrl.interface_enable && ctrl.format_select &&
      !tsel_r && scl_rise && !rx_halt_r && bcnt_r == 4'h7 &&
      !fl_r.rx_buffer_full |=> fl_r.rx_buffer_full &&
      rxb_r == $past(sh_in_w))
    else $error("sync byte not moved to receive buffer");
  a_sync_over:
    assert property (ctrl.interface_enable && ctrl.format_select &&
      !tsel_r && scl_rise && !rx_halt_r && bcnt_r == 4'h7 &&
      fl_r.rx_buffer_full |=> fl_r.arb_lost_or_overrun && $stable(rxb_r))
    else $error("overrun not flagged or buffer overwritten");
  a_filt_hold:
    assert property (f1_w[1] != f2_w[1] |=> $stable(filt_w[1]))
    else $error("filter passed a disagreeing sample");
  a_mon_wait:
    assert property ($fell(gen_low_r) |-> !gen_ok_r [*7])
    else $error("clock monitor ended too early");

  c_read_addr: cover property (st_r == tws_pkg::ST_AACK && scl_rise && dir_r);
  c_held_read: cover property (st_r == tws_pkg::ST_RHOLD && rx_rd);
  c_overrun: cover property ($rose(fl_r.arb_lost_or_overrun));
endmodule // tws_core

// ### core/tws_pkg.sv
// Constants, state codes and carrier types for the two-wire serial block.
package tws_pkg;
  localparam logic [7:0] BUF_RST = 8'hFF;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_SEVENTH = 4'h7;
  localparam int CKS_HI = 3;
  localparam int CKS_LO = 2;
  // Clock line monitor times in tenths of a system cycle.
  localparam int MON_T0_X10 = 75;
  localparam int MON_T1_X10 = 195;
  localparam int MON_T2_X10 = 175;
  localparam int MON_T3_X10 = 415;
  // Least times, so each rounds up to whole cycles.
  localparam logic [5:0] MON_C0 = 6'((MON_T0_X10 + 9) / 10);
  localparam logic [5:0] MON_C1 = 6'((MON_T1_X10 + 9) / 10);
  localparam logic [5:0] MON_C2 = 6'((MON_T2_X10 + 9) / 10);
  localparam logic [5:0] MON_C3 = 6'((MON_T3_X10 + 9) / 10);
  // Low phase of the generated transfer clock in system cycles.
  localparam logic [5:0] LOW_C = 6'h14;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ADDR = 10'h002,
    ST_AACK = 10'h004,
    ST_RXD = 10'h008,
    ST_RHOLD = 10'h010,
    ST_RACK = 10'h020,
    ST_TLOAD = 10'h040,
    ST_TXD = 10'h080,
    ST_TACK = 10'h100,
    ST_SKIP = 10'h200
  } tws_state_t;

  typedef struct packed {
    logic interface_enable;
    logic format_select;
    logic master_select;
    logic bit_order_select;
    logic ack_to_send;
    logic data_line_out_level;
    logic receive_disable;
    logic [3:0] clock_rate_select;
    logic [6:0] own_address;
  } tws_ctrl_t;

  typedef struct packed {
    logic tx_buffer_empty;
    logic tx_end_flag;
    logic rx_buffer_full;
    logic stop_seen;
    logic nack_seen_flag;
    logic arb_lost_or_overrun;
  } tws_flags_t;

  typedef struct packed {
    logic tx_empty_irq_enable;
    logic tx_end_irq_enable;
    logic rx_full_irq_enable;
    logic stop_seen_irq_enable;
    logic nack_error_irq_enable;
  } tws_irq_en_t;

  typedef struct packed {
    logic tx_empty_irq;
    logic tx_end_irq;
    logic rx_full_irq;
    logic stop_seen_irq;
    logic nack_error_irq;
  } tws_irq_t;
endpackage

// ### verification/tws_master_model.sv
// Behavioural remote master for the two-wire and synchronous links.
`timescale 1ns/100ps
module tws_master_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_rel,
  output logic sda_rel
);
  // Released lines float high through their pull-ups.
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end

  // Releases the clock and waits, bounded, while the device stretches it.
  task automatic rise_clock();
    scl_rel = 1'b1;
    for (int n = 0; n < 4000 && scl_line !== 1'b1; n++) begin
      #4;
    end
  endtask

  // Data falls while the clock is high; the clock goes low in the next bit.
  task automatic start_cond();
    sda_rel = 1'b1;
    rise_clock();
    #32;
    sda_rel = 1'b0;
    #32;
  endtask

  // Data rises while the clock is high, which ends the frame.
  task automatic stop_cond();
    scl_rel = 1'b0;
    #16;
    sda_rel = 1'b0;
    #16;
    rise_clock();
    #32;
    sda_rel = 1'b1;
    #32;
  endtask

  // Clocks n bits with a 64 ns period: 44 ns low, so the device has let go
  // of its acknowledge before the rise, and data moves 24 ns into the low.
  task automatic xfer(input int n, input logic [8:0] drv,
                      output logic [8:0] seen);
    seen = '0;
    for (int i = n - 1; i >= 0; i--) begin
      scl_rel = 1'b0;
      #24;
      sda_rel = drv[i];
      #20;
      rise_clock();
      #10;
      seen[i] = sda_line;
      #10;
    end
  endtask

  // A data dip that spans one system clock edge only.
  task automatic glitch();
    #2;
    sda_rel = 1'b0;
    #4;
    sda_rel = 1'b1;
  endtask
endmodule // tws_master_model

// ### verification/tws_core_tb.sv
// Self-checking bench for the two-wire and synchronous serial block.
`timescale 1ns/100ps
module tws_core_tb;
  logic clk_sys;
  logic rst_b;
  logic scl_w;
  logic sda_w;
  logic scl_out;
  logic scl_oe;
  logic sda_out;
  logic sda_oe;
  logic scl_rel;
  logic sda_rel;
  tws_pkg::tws_ctrl_t ctrl;
  tws_pkg::tws_irq_en_t irq_en;
  logic tx_wr;
  logic [7:0] tx_data;
  logic rx_rd;
  logic tsel_set;
  logic tsel_clr;
  tws_pkg::tws_flags_t flag_clr;
  logic [7:0] rx_data;
  tws_pkg::tws_flags_t flags;
  logic transmit_select;
  logic clock_line_monitor;
  tws_pkg::tws_irq_t irq;
  int mismatches;
  int check_count;
  int cycles;
  int ncap;
  logic cap_on;
  logic [7:0] cap;
  logic [8:0] seen;

  // Open-drain clock and pushed or pulled data, both with pull-ups.
  assign scl_w = (scl_oe ? scl_out : 1'b1) & scl_rel;
  assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_rel;

  tws_core i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_w),
    .sda_in(sda_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .ctrl(ctrl), .irq_en(irq_en), .tx_wr(tx_wr),
    .tx_data(tx_data), .rx_rd(rx_rd), .tsel_set(tsel_set),
    .tsel_clr(tsel_clr), .flag_clr(flag_clr), .rx_data(rx_data),
    .flags(flags), .transmit_select(transmit_select),
    .clock_line_monitor(clock_line_monitor), .irq(irq));

  tws_master_model i_master (.scl_line(scl_w), .sda_line(sda_w),
    .scl_rel(scl_rel), .sda_rel(sda_rel));

  // System clock at 200 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // Records synchronous bits at rising clock and watches data stability.
  always @(posedge scl_w) begin
    if (cap_on) begin
      cap = {cap[6:0], sda_w};
      ncap++;
    end
  end
  always @(sda_w) begin
    if (cap_on && scl_w && ncap > 0 && ncap < 8) begin
      $display("unexpected at %0t: data moved while clock high", $time);
      mismatches++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s", $time, msg);
      mismatches++;
    end
  endtask

  // One host strobe cycle; s is write, read, select set, select clear.
  task automatic host_op(input logic [3:0] s, input tws_pkg::tws_flags_t fc,
                         input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {tx_wr, rx_rd, tsel_set, tsel_clr} = s;
    flag_clr = fc;
    tx_data = d;
    @(posedge clk_sys);
    #1;
    {tx_wr, rx_rd, tsel_set, tsel_clr} = 4'h0;
    flag_clr = '0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    ctrl = '0;
    irq_en = 5'h1F;
    {tx_wr, rx_rd, tsel_set, tsel_clr} = 4'h0;
    flag_clr = '0;
    tx_data = 8'h00;
    cap_on = 1'b0;
    cap = 8'h00;
    repeat (20) @(posedge clk_sys);
    chk({rx_data, flags, sda_oe, scl_oe}, 16'hFF00, "reset values");
    #1;
    rst_b = 1'b1;
    ctrl.interface_enable = 1'b1;
    ctrl.own_address = 7'h2A;
    settle();
    // Slave receive with acknowledge change and clock stretch.
    i_master.start_cond();
    i_master.xfer(9, 9'h0A9, seen);
    settle();
    chk(seen[0], 1'b0, "address not acknowledged");
    chk({flags.rx_buffer_full, rx_data}, 9'h154, "address byte");
    host_op(4'h4, '0, 8'h00);
    chk(flags.rx_buffer_full, 1'b0, "full not cleared");
    i_master.xfer(9, 9'h14B, seen);
    settle();
    chk(rx_data, 8'hA5, "first data byte");
    host_op(4'h4, '0, 8'h00);
    ctrl.ack_to_send = 1'b1;
    i_master.xfer(9, 9'h079, seen);
    chk(seen[0], 1'b0, "ack changed too early");
    fork
      i_master.xfer(9, 9'h0B5, seen);
      begin
        repeat (150) @(posedge clk_sys);
        #1;
        chk(scl_oe, 1'b1, "clock not held while full");
        chk(rx_data, 8'h3C, "held byte");
        chk(clock_line_monitor, 1'b0, "monitor missed held clock");
        host_op(4'h4, '0, 8'h00);
      end
    join
    settle();
    chk(seen[0], 1'b1, "new ack not applied");
    chk({rx_data, irq.rx_full_irq}, 9'h0B5, "second byte");
    ctrl.ack_to_send = 1'b0;
    host_op(4'h4, '0, 8'h00);
    i_master.stop_cond();
    settle();
    chk({flags.stop_seen, irq.stop_seen_irq}, 2'h3, "stop");
    host_op(4'h0, 6'h04, 8'h00);
    // A foreign address is not answered.
    i_master.start_cond();
    i_master.xfer(9, 9'h0AD, seen);
    chk(seen[0], 1'b1, "foreign address answered");
    i_master.stop_cond();
    settle();
    host_op(4'h0, 6'h04, 8'h00);
    // A dip on the data line too short for the filter is not a condition.
    i_master.glitch();
    settle();
    chk(flags.stop_seen, 1'b0, "glitch seen as condition");
    // Slave transmit of two bytes and end of transfer.
    i_master.start_cond();
    i_master.xfer(9, 9'h0AB, seen);
    settle();
    chk({seen[0], transmit_select}, 2'h1, "read address");
    host_op(4'h8, '0, 8'hC3);
    chk({flags.tx_buffer_empty, flags.tx_end_flag}, 2'h0, "write");
    fork
      i_master.xfer(9, 9'h1FE, seen);
      begin
        for (int n = 0; n < 200 && flags.tx_buffer_empty !== 1'b1; n++) begin
          @(posedge clk_sys);
        end
        #1;
        chk(flags.tx_buffer_empty, 1'b1, "empty not set on load");
        host_op(4'h8, '0, 8'h96);
      end
    join
    chk(seen[8:1], 8'hC3, "first sent byte");
    i_master.xfer(9, 9'h1FF, seen);
    settle();
    chk(seen[8:1], 8'h96, "second sent byte");
    chk({flags.tx_end_flag, flags.nack_seen_flag}, 2'h3, "end flags");
    chk({irq.tx_end_irq, irq.nack_error_irq}, 2'h3, "requests");
    host_op(4'h0, 6'h12, 8'h00);
    host_op(4'h1, '0, 8'h00);
    host_op(4'h4, '0, 8'h00);
    host_op(4'h0, 6'h20, 8'h00);
    chk({scl_oe, transmit_select}, 2'h0, "clock not freed");
    i_master.stop_cond();
    settle();
    // Synchronous master transmit, least significant bit first.
    ctrl.format_select = 1'b1;
    ctrl.data_line_out_level = 1'b1;
    ctrl.bit_order_select = 1'b1;
    ctrl.clock_rate_select = 4'hC;
    settle();
    host_op(4'h2, '0, 8'h00);
    // Master only after transmit select, else a receive clock would start.
    ctrl.master_select = 1'b1;
    chk({flags.tx_buffer_empty, irq.tx_empty_irq}, 2'h3, "no empty");
    chk({sda_oe, sda_out}, 2'h3, "idle data level");
    ncap = 0;
    cap_on = 1'b1;
    host_op(4'h8, '0, 8'h4B);
    for (int n = 0; n < 3000 && flags.tx_end_flag !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    cap_on = 1'b0;
    chk(ncap, 8, "generated clock count");
    chk(cap, 8'hD2, "synchronous bit order");
    // Synchronous receive on an external clock, then an overrun.
    settle();
    ctrl.master_select = 1'b0;
    ctrl.bit_order_select = 1'b0;
    host_op(4'h1, '0, 8'h00);
    settle();
    i_master.xfer(8, 9'h096, seen);
    settle();
    chk({flags.rx_buffer_full, rx_data}, 9'h196, "sync receive");
    i_master.xfer(8, 9'h069, seen);
    settle();
    chk({flags.arb_lost_or_overrun, rx_data}, 9'h196, "overrun");
    chk(irq.nack_error_irq, 1'b1, "overrun request");
    // Master receive with receive disable takes one byte, then stops high.
    ctrl.master_select = 1'b1;
    ctrl.receive_disable = 1'b1;
    ncap = 0;
    cap_on = 1'b1;
    host_op(4'h4, '0, 8'h00);
    repeat (1500) @(posedge clk_sys);
    #1;
    chk({ncap[3:0], flags.rx_buffer_full, rx_data}, 13'h11FF, "halt");
    complete_run();
  end
endmodule // tws_core_tb
